// ==== logic/axis_enable_pkg.sv ====
// Constants and types for the axis enable controller.
// Assumes a single 100 MHz clock domain.
package axis_enable_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam logic [0:0] STOP_EMERGENCY = 1'h0;
  localparam logic [0:0] STOP_IMMEDIATE = 1'h1;
  localparam int unsigned VEL_WIDTH = 16;
  localparam logic [VEL_WIDTH-1:0] VEL_RESET = 16'h0000;
  localparam logic [15:0] FAULT_NONE = 16'h0000;
  localparam logic [15:0] FAULT_DRIVE_LOST = 16'h8001;
  localparam logic [15:0] FAULT_EXTERNAL = 16'h8002;
  localparam logic [15:0] DETAIL_NONE = 16'h0000;
  localparam logic [15:0] DETAIL_READY_DROP = 16'h0001;
  localparam logic [15:0] DETAIL_AXIS_FAULT = 16'h0002;
  typedef enum logic [2:0] {
    ST_OFF,
    ST_WAIT_READY,
    ST_ON,
    ST_RAMP_DOWN,
    ST_FAULTED
  } power_state_e;
endpackage

// ==== logic/axis_ramp_down.sv ====
// Velocity ramp used to bring the axis to rest at emergency deceleration.
// Assumes velocity and deceleration are unsigned magnitudes per clock.
`timescale 1ns/1ps
`default_nettype none
module axis_ramp_down
  import axis_enable_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic load_in,
  input wire logic [VEL_WIDTH-1:0] load_vel_in,
  input wire logic brake_in,
  input wire logic kill_in,
  input wire logic [VEL_WIDTH-1:0] decel_in,
  output logic [VEL_WIDTH-1:0] vel_out
);
  logic [VEL_WIDTH-1:0] next_vel;

  always_comb
  begin
    next_vel = vel_out;
    if (kill_in)
    begin
      next_vel = VEL_RESET;
    end
    else if (brake_in)
    begin
      // Saturate at zero so a big step never wraps
      next_vel = (vel_out > decel_in) ? vel_out - decel_in : VEL_RESET;
    end
    else if (load_in)
    begin
      next_vel = load_vel_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      vel_out <= VEL_RESET;
    end
    else
    begin
      vel_out <= next_vel;
    end
  end
endmodule
`default_nettype wire

// ==== logic/axis_enable_control.sv ====
// Axis enable controller: drive power, enable status, stop handling.
// Assumes user inputs and drive-ready are synchronous to clk_in.
// Functional notes
// RULE1 - Enable low aborts tasks, stops axis
// RULE2 - Enable high starts enable attempt
// RULE3 - Emergency stop ramps down, then disables
// RULE4 - Immediate stop disables, kills pulses now
// RULE5 - Disabled axis runs and accepts no tasks
// RULE6 - Disabled axis reports not homed
// RULE7 - Status stays high until standstill
// RULE8 - Status waits for drive ready
// RULE9 - No ready input: status immediately
// RULE10 - Busy shows enable function active
// RULE11 - Faults raise error with code, detail
// RULE12 - Enable request powers the drive
// RULE13 - Drive ready marks axis enabled
// RULE14 - User sets stop mode before enable
// RULE15 - User stops axis before disabling
// RULE16 - Disable done when busy, status low
// RULE17 - Re-enable allowed after acknowledged fault
// RULE18 - Held enable re-enables after acknowledge
// RULE19 - Tasks never abort this function
// RULE20 - Enabled flag mirrors status output
`timescale 1ns/1ps
`default_nettype none
module axis_enable_control
  import axis_enable_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic enable_request_in,
  input wire logic stop_behaviour_select_in,
  input wire logic ready_configured_in,
  input wire logic drive_ready_in,
  input wire logic axis_fault_in,
  input wire logic fault_acknowledge_task_in,
  input wire logic task_start_in,
  input wire logic homed_event_in,
  input wire logic [VEL_WIDTH-1:0] task_velocity_in,
  input wire logic [VEL_WIDTH-1:0] emergency_decel_in,
  output logic status_out,
  output logic axis_enabled_flag_out,
  output logic busy_out,
  output logic error_out,
  output logic [15:0] fault_code_out,
  output logic [15:0] fault_detail_out,
  output logic drive_enable_out,
  output logic pulse_enable_out,
  output logic task_accept_out,
  output logic task_reject_out,
  output logic homed_out,
  output logic axis_at_rest_flag_out,
  output logic [VEL_WIDTH-1:0] velocity_out
);
  logic rst_meta, rst_n;
  power_state_e state, next_state;
  logic next_status, next_busy, next_error, next_drive, next_pulse;
  logic next_accept, next_reject, next_homed, next_rest;
  logic [15:0] next_code, next_detail;
  logic task_active, next_task_active;
  logic load, brake, kill;
  logic [VEL_WIDTH-1:0] vel;

  default clocking dc @(posedge clk_in);
  endclocking
  default disable iff (!rst_n);

  // Reset released through two flops; async assert
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  axis_ramp_down u_ramp (
    .clk_in(clk_in),
    .reset_n_in(rst_n),
    .load_in(load),
    .load_vel_in(task_velocity_in),
    .brake_in(brake),
    .kill_in(kill),
    .decel_in(emergency_decel_in),
    .vel_out(vel)
  );

  always_comb
  begin
    next_state = state;
    next_status = status_out;
    next_busy = busy_out;
    next_error = error_out;
    next_code = fault_code_out;
    next_detail = fault_detail_out;
    next_drive = drive_enable_out;
    next_accept = 1'b0;
    next_reject = 1'b0;
    next_homed = homed_out;
    next_task_active = task_active;
    load = 1'b0;
    brake = 1'b0;
    kill = 1'b0;
    unique case (state)
      ST_OFF:
      begin
        next_status = 1'b0;
        next_drive = 1'b0;
        next_task_active = 1'b0;
        kill = 1'b1;
        next_busy = enable_request_in;
        if (enable_request_in)
        begin
          next_drive = 1'b1; // RULE12
          if (ready_configured_in)
          begin
            next_state = ST_WAIT_READY; // RULE2
          end
          else
          begin
            next_status = 1'b1; // RULE9
            next_state = ST_ON;
          end
        end
      end
      ST_WAIT_READY:
      begin
        kill = 1'b1;
        if (!enable_request_in)
        begin
          next_drive = 1'b0;
          next_busy = 1'b0;
          next_state = ST_OFF;
        end
        else if (drive_ready_in)
        begin
          next_status = 1'b1; // RULE13
          next_state = ST_ON;
        end
        else
        begin
          next_status = 1'b0; // RULE8
        end
      end
      ST_ON:
      begin
        // Task starts are ignored as abort sources here
        if (task_start_in)
        begin
          next_accept = 1'b1; // RULE19
          next_task_active = 1'b1;
          load = 1'b1;
        end
        if (homed_event_in)
        begin
          next_homed = 1'b1;
        end
        if (!enable_request_in)
        begin
          next_task_active = 1'b0; // RULE1
          if (stop_behaviour_select_in == STOP_IMMEDIATE)
          begin
            kill = 1'b1; // RULE4
            load = 1'b0;
            next_status = 1'b0;
            next_drive = 1'b0;
            next_busy = 1'b0;
            next_homed = 1'b0;
            next_state = ST_OFF;
          end
          else
          begin
            load = 1'b0;
            next_state = ST_RAMP_DOWN; // RULE3
          end
        end
      end
      ST_RAMP_DOWN:
      begin
        brake = 1'b1; // RULE3
        if (vel == VEL_RESET)
        begin
          next_status = 1'b0; // RULE7
          next_drive = 1'b0;
          next_busy = 1'b0; // RULE16
          next_homed = 1'b0;
          next_state = ST_OFF;
        end
      end
      ST_FAULTED:
      begin
        kill = 1'b1;
        next_task_active = 1'b0;
        if (fault_acknowledge_task_in && !axis_fault_in)
        begin
          next_error = 1'b0; // RULE17
          next_code = FAULT_NONE;
          next_detail = DETAIL_NONE;
          next_busy = enable_request_in;
          if (enable_request_in)
          begin
            next_drive = 1'b1; // RULE18
            next_state = ready_configured_in ? ST_WAIT_READY : ST_ON;
            next_status = !ready_configured_in;
          end
          else
          begin
            next_state = ST_OFF;
          end
        end
      end
      default:
      begin
        next_state = ST_OFF;
      end
    endcase
    // Faults win over any other transition except those out of ST_OFF
    if (state != ST_FAULTED && state != ST_OFF
        && (axis_fault_in || (state == ST_ON && ready_configured_in && !drive_ready_in)))
    begin
      next_error = 1'b1; // RULE11
      next_code = axis_fault_in ? FAULT_EXTERNAL : FAULT_DRIVE_LOST;
      next_detail = axis_fault_in ? DETAIL_AXIS_FAULT : DETAIL_READY_DROP;
      next_status = 1'b0;
      next_drive = 1'b0;
      next_homed = 1'b0;
      next_task_active = 1'b0;
      next_accept = 1'b0;
      load = 1'b0;
      kill = 1'b1;
      next_state = ST_FAULTED;
    end
    // Off states refuse tasks; acknowledge is a separate input
    if (task_start_in && state != ST_ON)
    begin
      next_reject = 1'b1; // RULE5
    end
    if (next_state == ST_OFF || next_state == ST_FAULTED || next_state == ST_WAIT_READY)
    begin
      next_homed = 1'b0; // RULE6
    end
    next_pulse = (next_state == ST_ON || next_state == ST_RAMP_DOWN) && !kill; // RULE4
    next_rest = (next_state != ST_ON || !next_task_active) || kill;
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_OFF;
      status_out <= 1'b0;
      axis_enabled_flag_out <= 1'b0;
      busy_out <= 1'b0;
      error_out <= 1'b0;
      fault_code_out <= FAULT_NONE;
      fault_detail_out <= DETAIL_NONE;
      drive_enable_out <= 1'b0;
      pulse_enable_out <= 1'b0;
      task_accept_out <= 1'b0;
      task_reject_out <= 1'b0;
      homed_out <= 1'b0;
      axis_at_rest_flag_out <= 1'b1;
      task_active <= 1'b0;
      velocity_out <= VEL_RESET;
    end
    else
    begin
      state <= next_state;
      status_out <= next_status;
      axis_enabled_flag_out <= next_status; // RULE20
      busy_out <= next_busy; // RULE10
      error_out <= next_error;
      fault_code_out <= next_code;
      fault_detail_out <= next_detail;
      drive_enable_out <= next_drive;
      pulse_enable_out <= next_pulse;
      task_accept_out <= next_accept;
      task_reject_out <= next_reject;
      homed_out <= next_homed;
      axis_at_rest_flag_out <= next_rest;
      task_active <= next_task_active;
      velocity_out <= vel;
    end
  end

  property p_flag_mirror;
    axis_enabled_flag_out == status_out;
  endproperty
  a_flag_mirror: assert property (p_flag_mirror) else $error("Flag differs from status"); // RULE20
  property p_no_ready_fast;
    (state == ST_OFF && enable_request_in && !ready_configured_in && !axis_fault_in)
      |=> status_out && drive_enable_out;
  endproperty
  a_no_ready_fast: assert property (p_no_ready_fast) else $error("Status not immediate"); // RULE9
  property p_wait_ready;
    (state == ST_WAIT_READY) |-> !status_out;
  endproperty
  a_wait_ready: assert property (p_wait_ready) else $error("Status before ready"); // RULE8
  property p_ready_enables;
    (state == ST_WAIT_READY && enable_request_in && drive_ready_in && !axis_fault_in)
      |=> status_out ##0 state == ST_ON;
  endproperty
  a_ready_enables: assert property (p_ready_enables) else $error("Ready did not enable"); // RULE13
  property p_immediate;
    (state == ST_ON && !enable_request_in && stop_behaviour_select_in && !axis_fault_in)
      |=> !pulse_enable_out && !status_out && !busy_out;
  endproperty
  a_immediate: assert property (p_immediate) else $error("Immediate stop late"); // RULE4
  property p_ramp_status;
    (state == ST_RAMP_DOWN && vel != VEL_RESET && !axis_fault_in) |=> status_out;
  endproperty
  a_ramp_status: assert property (p_ramp_status) else $error("Status dropped moving"); // RULE7
  property p_reject;
    (task_start_in && state != ST_ON) |=> task_reject_out && !task_accept_out;
  endproperty
  a_reject: assert property (p_reject) else $error("Task not rejected"); // RULE5
  property p_not_homed;
    !status_out && state != ST_RAMP_DOWN |-> !homed_out;
  endproperty
  a_not_homed: assert property (p_not_homed) else $error("Homed while disabled"); // RULE6
  property p_fault;
    (axis_fault_in && state == ST_ON) |=> error_out && fault_code_out == FAULT_EXTERNAL;
  endproperty
  a_fault: assert property (p_fault) else $error("Fault not reported"); // RULE11

  c_enable: cover property ($rose(status_out));
  c_ramp: cover property (state == ST_RAMP_DOWN ##1 state == ST_OFF);
  c_refault: cover property (state == ST_FAULTED ##1 state == ST_ON);
endmodule
`default_nettype wire

// ==== tb/drive_model.sv ====
// Motor drive model: raises ready a set delay after power-on.
// Assumes the bench gives the delay and any commanded loss of ready.
`timescale 1ns/1ps
`default_nettype none
module drive_model
(
  input wire logic clk_in,
  input wire logic drive_enable_in,
  input wire logic drop_in,
  input wire logic [3:0] delay_in,
  output logic drive_ready_out
);
  logic [3:0] count;
  logic [3:0] next_count;
  always_comb
  begin
    next_count = count;
    if (!drive_enable_in)
      next_count = 4'h0;
    else if (count != delay_in)
      next_count = count + 4'h1;
  end
  always_ff @(posedge clk_in)
  begin
    count <= next_count;
    // Unpowered drive never claims ready
    drive_ready_out <= drive_enable_in && (next_count == delay_in) && !drop_in;
  end
endmodule
`default_nettype wire

// ==== tb/axis_enable_control_tb.sv ====
// Bench for the axis enable controller with a drive model.
// Assumes one 100 MHz clock and the design's two-flop reset release.
`timescale 1ns/1ps
`default_nettype none
module axis_enable_control_tb;
  import axis_enable_pkg::*;
  localparam logic [41:0] M_ALL = '1;
  localparam logic [41:0] M_NR = {10'h3fb, 32'hffffffff};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic en = 1'b0, sel = 1'b0, rcfg = 1'b0, fault = 1'b0, ack = 1'b0;
  logic start = 1'b0, hev = 1'b0, drop = 1'b0;
  logic [15:0] vel, dec, vel_o, code, detail;
  logic [3:0] dly;
  logic st, flg, busy, err, drv, pls, acc, rej, homed, rest, ready;
  logic [41:0] exp_q[$];
  logic [41:0] mask_q[$];
  event sample_ev;
  int failures = 0;
  int samples_checked = 0;
  wire logic [41:0] obs = {st, flg, busy, drv, pls, err, homed, rest, acc, rej, code, detail};

  initial
  begin
    forever #5 clk = ~clk;
  end

  axis_enable_control u_axis_enable_control (.clk_in(clk), .reset_n_in(reset_n),
    .enable_request_in(en), .stop_behaviour_select_in(sel), .ready_configured_in(rcfg),
    .drive_ready_in(ready), .axis_fault_in(fault), .fault_acknowledge_task_in(ack),
    .task_start_in(start), .homed_event_in(hev), .task_velocity_in(vel),
    .emergency_decel_in(dec), .status_out(st), .axis_enabled_flag_out(flg),
    .busy_out(busy), .error_out(err), .fault_code_out(code), .fault_detail_out(detail),
    .drive_enable_out(drv), .pulse_enable_out(pls), .task_accept_out(acc),
    .task_reject_out(rej), .homed_out(homed), .axis_at_rest_flag_out(rest),
    .velocity_out(vel_o));

  drive_model u_drive_model (.clk_in(clk), .drive_enable_in(drv), .drop_in(drop),
    .delay_in(dly), .drive_ready_out(ready));

  task check(input logic [41:0] seen, input logic [41:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task end_of_test;
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task note(input logic [41:0] want, input logic [41:0] m);
    exp_q.push_back(want);
    mask_q.push_back(m);
    ->sample_ev;
  endtask

  always @(sample_ev)
  begin
    check(obs & mask_q[0], exp_q[0] & mask_q[0]);
    void'(exp_q.pop_front());
    void'(mask_q.pop_front());
  end

  function automatic logic [41:0] mk(input logic [9:0] f, input logic [15:0] c,
    input logic [15:0] d);
    return {f, c, d};
  endfunction

  task cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task kick(input logic s, input logic h);
    @(posedge clk);
    start <= s;
    hev <= h;
    vel <= 16'($urandom_range(255, 1));
    @(posedge clk);
    start <= 1'b0;
    hev <= 1'b0;
    @(negedge clk);
  endtask

  // Bounded: a hang here ends the run as a failure
  task wait_st(input logic v);
    int i;
    i = 0;
    do
    begin
      cyc(0);
      i++;
    end
    while (st !== v && i < 400);
    if (i == 400)
    begin
      failures++;
      $display("BAD %0t timeout", $time);
      end_of_test();
    end
  endtask

  initial
  begin
    vel = 16'h0;
    dly = 4'h0;
    void'($urandom(32'h1592));
    dec = 16'($urandom_range(15, 1));
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    cyc(4);
    note(mk(10'h004, FAULT_NONE, DETAIL_NONE), M_ALL);
    kick(1'b1, 1'b1);
    note(mk(10'h005, FAULT_NONE, DETAIL_NONE), M_ALL);
    @(posedge clk);
    sel <= STOP_IMMEDIATE;
    en <= 1'b1;
    cyc(1);
    // Pulses open one cycle after status: the off state still holds the ramp killed
    note(mk(10'h3c0, FAULT_NONE, DETAIL_NONE), M_NR);
    kick(1'b1, 1'b1);
    note(mk(10'h3ea, FAULT_NONE, DETAIL_NONE), M_NR);
    @(posedge clk);
    en <= 1'b0;
    cyc(1);
    note(mk(10'h000, FAULT_NONE, DETAIL_NONE), M_NR);
    cyc(0);
    check(vel_o, VEL_RESET);
    // Slow drive: status must wait for ready
    @(posedge clk);
    rcfg <= 1'b1;
    dly <= 4'($urandom_range(9, 2));
    sel <= STOP_EMERGENCY;
    en <= 1'b1;
    cyc(1);
    note(mk(10'h0c0, FAULT_NONE, DETAIL_NONE), M_NR);
    for (int i = 0; i < 20 && ready !== 1'b1; i++)
    begin
      check(st, 1'b0);
      cyc(0);
    end
    check(ready, 1'b1);
    cyc(0);
    note(mk(10'h3c0, FAULT_NONE, DETAIL_NONE), M_NR);
    kick(1'b1, 1'b0);
    note(mk(10'h3e2, FAULT_NONE, DETAIL_NONE), M_NR);
    @(posedge clk);
    en <= 1'b0;
    for (int i = 0; i < 400 && st === 1'b1; i++)
    begin
      cyc(0);
      if (st === 1'b1 && vel_o !== VEL_RESET)
        check(pls, 1'b1);
    end
    check(vel_o, VEL_RESET);
    note(mk(10'h000, FAULT_NONE, DETAIL_NONE), M_NR);
    // Axis fault, then loss of drive ready
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      rcfg <= k[0];
      en <= 1'b1;
      wait_st(1'b1);
      @(posedge clk);
      fault <= (k == 0);
      drop <= (k == 1);
      cyc(1 + k);
      note(mk(10'h094, k ? FAULT_DRIVE_LOST : FAULT_EXTERNAL,
        k ? DETAIL_READY_DROP : DETAIL_AXIS_FAULT), M_ALL);
      @(posedge clk);
      fault <= 1'b0;
      drop <= 1'b0;
      ack <= 1'b1;
      wait_st(1'b1);
      note(mk(10'h3c0, FAULT_NONE, DETAIL_NONE), M_NR);
      check(rest, 1'b1);
      @(posedge clk);
      ack <= 1'b0;
      en <= 1'b0;
      wait_st(1'b0);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
